/* dtc_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts for
 * the converter register bank. Assumes inclusion by bare name.
 */
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

`define DTC_OFF_CODE 8'h21
`define DTC_OFF_MHIGH 8'h25
`define DTC_OFF_MLOW 8'h26
`define DTC_OFF_ACTION 8'hd3

`define DTC_CODE_MSB 11
`define DTC_CODE_LSB 2

`define DTC_UNLOCK_MSB 15
`define DTC_UNLOCK_LSB 12
`define DTC_UNLOCK_KEY 4'h5
`define DTC_BIT_FACTORY 9
`define DTC_BIT_WAVE 8
`define DTC_BIT_MHIGH 7
`define DTC_BIT_MLOW 6
`define DTC_BIT_RECALL 5
`define DTC_BIT_SAVE 4
`define DTC_KEY_MSB 3
`define DTC_KEY_LSB 0
`define DTC_KEY_IDLE 4'h8
`define DTC_KEY_GO 4'ha

`define DTC_RST_CODE 10'h000
`define DTC_RST_ACTION 16'h0008

`define DTC_STORE_NS 40
`define DTC_CLK_NS 4
`define DTC_STORE_CYC ((`DTC_STORE_NS + `DTC_CLK_NS - 1) / `DTC_CLK_NS)

`endif

/* dtc_pkg.sv */
/*
 * Types for the converter register bank.
 * Assumes dtc_regs.svh supplies the numbers.
 */
package dtc_pkg;
   typedef logic [9:0] dtc_code_t;
   typedef enum logic [1:0] {
      DTC_IDLE = 2'b00,
      DTC_RECALL = 2'b01,
      DTC_SAVE = 2'b10
   } dtc_store_t;
endpackage

/* dtc_store_if.sv */
/*
 * Link between the register bank and its nonvolatile store.
 * Assumes both ends run on the one device clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface dtc_store_if;
   logic save;
   logic recall;
   dtc_pkg::dtc_code_t wr_code;
   dtc_pkg::dtc_code_t wr_high;
   dtc_pkg::dtc_code_t wr_low;
   dtc_pkg::dtc_code_t rd_code;
   dtc_pkg::dtc_code_t rd_high;
   dtc_pkg::dtc_code_t rd_low;
   modport bank (output save, recall, wr_code, wr_high, wr_low,
                 input rd_code, rd_high, rd_low);
   modport store (input save, recall, wr_code, wr_high, wr_low,
                  output rd_code, rd_high, rd_low);
endinterface
`default_nettype wire

/* dtc_store_mem.sv */
/*
 * Nonvolatile image of the converter codes, modelled as registers.
 * Assumes save and recall come as one-cycle pulses from the bank.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_store_mem (
   input wire logic clk, // Device clock.
   input wire logic rst_n, // Synchronous reset, active low.
   dtc_store_if.store st // Save and recall link.
);
   dtc_pkg::dtc_code_t img_q [3];
   dtc_pkg::dtc_code_t img_d [3];
   dtc_pkg::dtc_code_t rd_q [3];
   dtc_pkg::dtc_code_t rd_d [3];

   // The image survives the bank reset; only the read register clears.
   always_comb begin
      img_d = img_q;
      rd_d = rd_q;
      if (st.save) begin
         img_d[0] = st.wr_code;
         img_d[1] = st.wr_high;
         img_d[2] = st.wr_low;
      end
      if (st.recall) begin
         rd_d = img_q;
      end
   end

   always_ff @(posedge clk) begin
      img_q <= img_d;
      if (!rst_n) begin
         rd_q <= '{`DTC_RST_CODE, `DTC_RST_CODE, `DTC_RST_CODE};
      end else begin
         rd_q <= rd_d;
      end
   end

   // The image holds no defined codes until the first save has run.

   assign st.rd_code = rd_q[0];
   assign st.rd_high = rd_q[1];
   assign st.rd_low = rd_q[2];
endmodule
`default_nettype wire

/* dtc_bank.sv */
/*
 * Action, output code and margin registers of a single-channel converter.
 * Assumes a bus engine on clk presents one-cycle write and read strobes.
 */
// Function
// - Unlock key 0101 in top nibble bypasses lock
// - Bit 9 restores factory values in the bank; the store image keeps its codes
// - Bit 8 runs or stops waveform mode
// - Bit 7 slews code to upper margin
// - Bit 6 slews code to lower margin
// - Bit 5 recalls store; busy meanwhile
// - Bit 4 saves to store; busy meanwhile
// - Key 1010 reloads codes, defaults rest
// - Output code write takes effect immediately
// - Output code sits in bits 11..2
// - Upper margin code sits in bits 11..2
// - Lower margin code sits in bits 11..2
`timescale 1ns/10ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_bank (
   input wire logic clk, // Device clock, 250 MHz.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic wr_en, // Register write strobe.
   input wire logic rd_en, // Register read strobe.
   input wire logic [7:0] addr, // Register address.
   input wire logic [15:0] wdata, // Write data.
   output logic [15:0] rdata, // Read data, valid cycle after rd_en.
   output logic [9:0] active_code, // Code driving the converter.
   output logic waveform_run, // Continuous waveform mode enabled.
   output logic unlocked, // Lock flag bypassed.
   output logic store_busy_flag // Store recall (bit 5) or save (bit 4) in progress; the key 1010 reload does not raise it.
);
   dtc_pkg::dtc_code_t code_q, code_d, high_q, high_d, low_q, low_d;
   logic run_q, run_d, unl_q, unl_d, up_q, up_d, dn_q, dn_d;
   logic rc_q, rc_d, sv_q, sv_d;
   logic ld_q, ld_d;
   logic [15:0] rdata_q, rdata_d;
   logic [7:0] cnt_q, cnt_d;
   dtc_pkg::dtc_store_t op_q, op_d;
   logic act_wr, factory, restart, save_p, recall_p, done;
   dtc_store_if st ();

   dtc_store_mem u_mem (
      .clk(clk),
      .rst_n(rst_n),
      .st(st.store)
   );

   assign act_wr = wr_en && (addr == `DTC_OFF_ACTION);
   assign factory = act_wr && wdata[`DTC_BIT_FACTORY];
   assign restart = act_wr &&
      (wdata[`DTC_KEY_MSB:`DTC_KEY_LSB] == `DTC_KEY_GO);
   assign done = (op_q != dtc_pkg::DTC_IDLE) &&
      (cnt_q == 8'(`DTC_STORE_CYC));
   assign save_p = (op_q == dtc_pkg::DTC_SAVE) && done;
   assign recall_p = ((op_q == dtc_pkg::DTC_RECALL) && done) || restart;
   assign st.save = save_p;
   assign st.recall = recall_p;
   assign st.wr_code = code_q;
   assign st.wr_high = high_q;
   assign st.wr_low = low_q;

   // Store sequencer: recall or save runs a fixed time with busy high.
   always_comb begin
      op_d = op_q;
      cnt_d = cnt_q;
      rc_d = rc_q;
      sv_d = sv_q;
      // Store read data is registered, so the codes load a cycle later.
      ld_d = recall_p;
      case (op_q)
         dtc_pkg::DTC_IDLE: begin
            cnt_d = 8'h00;
            if (act_wr && wdata[`DTC_BIT_RECALL] && !factory) begin
               op_d = dtc_pkg::DTC_RECALL;
               rc_d = 1'b1;
            end else if (act_wr && wdata[`DTC_BIT_SAVE] && !factory) begin
               op_d = dtc_pkg::DTC_SAVE;
               sv_d = 1'b1;
            end
         end
         default: begin
            cnt_d = cnt_q + 8'h01;
            if (done) begin
               op_d = dtc_pkg::DTC_IDLE;
               rc_d = 1'b0;
               sv_d = 1'b0;
            end
         end
      endcase
      if (factory) begin
         op_d = dtc_pkg::DTC_IDLE;
         cnt_d = 8'h00;
         rc_d = 1'b0;
         sv_d = 1'b0;
         ld_d = 1'b0;
      end
   end

   // Codes, margins and action bits.
   always_comb begin
      code_d = code_q;
      high_d = high_q;
      low_d = low_q;
      run_d = run_q;
      unl_d = unl_q;
      up_d = up_q;
      dn_d = dn_q;
      if (up_q) begin
         if (code_q == high_q) begin
            up_d = 1'b0;
         end else if (code_q < high_q) begin
            code_d = code_q + 10'h001;
         end else begin
            code_d = code_q - 10'h001;
         end
      end else if (dn_q) begin
         if (code_q == low_q) begin
            dn_d = 1'b0;
         end else if (code_q > low_q) begin
            code_d = code_q - 10'h001;
         end else begin
            code_d = code_q + 10'h001;
         end
      end
      if (wr_en) begin
         if (addr == `DTC_OFF_CODE) begin
            code_d = wdata[`DTC_CODE_MSB:`DTC_CODE_LSB];
         end else if (addr == `DTC_OFF_MHIGH) begin
            high_d = wdata[`DTC_CODE_MSB:`DTC_CODE_LSB];
         end else if (addr == `DTC_OFF_MLOW) begin
            low_d = wdata[`DTC_CODE_MSB:`DTC_CODE_LSB];
         end else if (addr == `DTC_OFF_ACTION) begin
            if (wdata[`DTC_UNLOCK_MSB:`DTC_UNLOCK_LSB] == `DTC_UNLOCK_KEY) begin
               unl_d = 1'b1;
            end
            run_d = wdata[`DTC_BIT_WAVE];
            if (wdata[`DTC_BIT_MHIGH]) begin
               up_d = 1'b1;
               dn_d = 1'b0;
            end else if (wdata[`DTC_BIT_MLOW]) begin
               dn_d = 1'b1;
               up_d = 1'b0;
            end
         end
      end
      if (ld_q) begin
         code_d = st.rd_code;
         high_d = st.rd_high;
         low_d = st.rd_low;
      end
      if (restart) begin
         run_d = 1'b0;
         unl_d = 1'b0;
         up_d = 1'b0;
         dn_d = 1'b0;
      end
      if (factory) begin
         code_d = `DTC_RST_CODE;
         high_d = `DTC_RST_CODE;
         low_d = `DTC_RST_CODE;
         run_d = 1'b0;
         unl_d = 1'b0;
         up_d = 1'b0;
         dn_d = 1'b0;
      end
   end

   // Read data: only the self-clearing margin bits read back; the key always reads as idle.
   always_comb begin
      rdata_d = rdata_q;
      if (rd_en) begin
         rdata_d = 16'h0000;
         if (addr == `DTC_OFF_ACTION) begin
            rdata_d = `DTC_RST_ACTION;
            rdata_d[`DTC_BIT_MHIGH] = up_q;
            rdata_d[`DTC_BIT_MLOW] = dn_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         code_q <= `DTC_RST_CODE;
         high_q <= `DTC_RST_CODE;
         low_q <= `DTC_RST_CODE;
         run_q <= 1'b0;
         unl_q <= 1'b0;
         up_q <= 1'b0;
         dn_q <= 1'b0;
         rc_q <= 1'b0;
         sv_q <= 1'b0;
         ld_q <= 1'b0;
         op_q <= dtc_pkg::DTC_IDLE;
         cnt_q <= 8'h00;
         rdata_q <= 16'h0000;
      end else begin
         code_q <= code_d;
         high_q <= high_d;
         low_q <= low_d;
         run_q <= run_d;
         unl_q <= unl_d;
         up_q <= up_d;
         dn_q <= dn_d;
         rc_q <= rc_d;
         sv_q <= sv_d;
         ld_q <= ld_d;
         op_q <= op_d;
         cnt_q <= cnt_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;
   assign active_code = code_q;
   assign waveform_run = run_q;
   assign unlocked = unl_q;
   assign store_busy_flag = rc_q || sv_q;
endmodule
`default_nettype wire

/* dtc_bank_asserts.sv */
/* Port checks for the converter register bank.
   Assumes a bind from the testbench top file. */
`timescale 1ns/10ps
`default_nettype none
module dtc_bank_asserts (
   input wire logic clk, // Clock.
   input wire logic rst_n, // Reset.
   input wire logic wr_en, // Write.
   input wire logic rd_en, // Read.
   input wire logic [7:0] addr, // Address.
   input wire logic [15:0] wdata, // Data in.
   input wire logic [15:0] rdata, // Data out.
   input wire logic [9:0] active_code, // Code.
   input wire logic waveform_run, // Wave.
   input wire logic unlocked, // Unlock.
   input wire logic store_busy_flag // Busy.
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence act_wr;
      wr_en && addr == 8'hd3 && !wdata[9] && wdata[3:0] != 4'ha;
   endsequence
   sequence store_go;
      act_wr ##0 !store_busy_flag && (wdata[5] || wdata[4]);
   endsequence
   AST_CODE: assert property (
      wr_en && addr == 8'h21 |=> active_code == $past(wdata[11:2]))
      else $error("code not applied");
   AST_UNLOCK: assert property (
      act_wr ##0 wdata[15:12] == 4'h5 |=> unlocked)
      else $error("unlock missed");
   AST_WAVE: assert property (
      act_wr |=> waveform_run == $past(wdata[8]))
      else $error("wave bit wrong");
   AST_FACTORY: assert property (
      wr_en && addr == 8'hd3 && wdata[9] |=>
      !unlocked && !waveform_run && active_code == 10'h000)
      else $error("factory restore missed");
   AST_BUSY: assert property (
      store_go |=> store_busy_flag [*8])
      else $error("busy short");
   AST_DONE: assert property (
      $rose(store_busy_flag) |-> ##[10:12] !store_busy_flag)
      else $error("busy too long");
   AST_ZERO: assert property (
      act_wr ##0 wdata[7:4] == 4'h0 && !store_busy_flag
      |=> !store_busy_flag)
      else $error("zero write started work");
   AST_WO: assert property (
      rd_en && addr inside {8'h21, 8'h25, 8'h26} |=> rdata == 16'h0000)
      else $error("write-only read nonzero");
endmodule
`default_nettype wire

/* dtc_host.sv */
/* Host side model issuing register cycles.
   Assumes one-cycle strobes sampled on the rising edge. */
`timescale 1ns/10ps
`default_nettype none
module dtc_host (
   input wire logic clk, // Clock.
   output logic wr_en, // Write.
   output logic rd_en, // Read.
   output logic [7:0] addr, // Address.
   output logic [15:0] wdata, // Data out.
   input wire logic [15:0] rdata // Data in.
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
   end
   // Released lines show inverted values so stale data is never reused.
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   task rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      addr <= ~a;
      @(negedge clk);
      d = rdata;
   endtask
endmodule
`default_nettype wire

/* test_dtc_bank.sv */
/* Self-checking bench for the register bank.
   Assumes dtc_host and dtc_bank_asserts are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module test_dtc_bank;
   logic clk, rst_n, wr_en, rd_en, wave, unl, busy;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, v;
   logic [9:0] code;
   int failures, samples_checked;
   dtc_bank dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata), .rdata(rdata), .active_code(code),
      .waveform_run(wave), .unlocked(unl), .store_busy_flag(busy));
   dtc_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task test_done;
      if (failures == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task rchk(input logic [7:0] a, input logic [15:0] e);
      host.rd(a, v);
      chk("rdata", e, v);
   endtask
   task wcode(input logic [9:0] e);
      for (int n = 0; n < 1100 && code !== e; n++) @(negedge clk);
      chk("active_code", {6'h00, e}, {6'h00, code});
   endtask
   task flags(input logic [2:0] e);
      @(negedge clk);
      chk("busy,unlock,wave", {13'h0000, e}, {13'h0000, busy, unl, wave});
   endtask
   task wbusy;
      for (int n = 0; n < 40 && busy !== 1'b0; n++) @(negedge clk);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      test_done;
   end
   initial begin
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rchk(8'hd3, 16'h0008);
      rchk(8'h21, 16'h0000);
      rchk(8'h77, 16'h0000);
      host.wr(8'h21, 16'hf3ff);
      wcode(10'h0ff);
      host.wr(8'h25, 16'h07fc);
      host.wr(8'hd3, 16'h0088);
      rchk(8'hd3, 16'h0088);
      wcode(10'h1ff);
      rchk(8'hd3, 16'h0008);
      host.wr(8'h26, 16'hf013);
      host.wr(8'hd3, 16'h0048);
      wcode(10'h004);
      rchk(8'hd3, 16'h0008);
      host.wr(8'hd3, 16'h0018);
      flags(3'b100);
      host.wr(8'hd3, 16'h0008);
      flags(3'b100);
      wbusy;
      host.wr(8'h21, 16'h0000);
      host.wr(8'hd3, 16'h0028);
      flags(3'b100);
      wcode(10'h004);
      host.wr(8'h21, 16'h0000);
      host.wr(8'hd3, 16'h5108);
      flags(3'b011);
      host.wr(8'hd3, 16'h000a);
      wbusy;
      wcode(10'h004);
      flags(3'b000);
      host.wr(8'hd3, 16'h5108);
      host.wr(8'hd3, 16'h0008);
      flags(3'b010);
      host.wr(8'hd3, 16'h0208);
      flags(3'b000);
      wcode(10'h000);
      test_done;
   end
endmodule
bind dtc_bank dtc_bank_asserts chk_i (.clk(clk), .rst_n(rst_n),
   .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
   .rdata(rdata), .active_code(active_code), .waveform_run(waveform_run),
   .unlocked(unlocked), .store_busy_flag(store_busy_flag));
`default_nettype wire
